// ### dic_consts.svh
// Function
// - Accept jack, GPIO, DSP, detect, lock, peripheral inputs
// - Two independent flag and mask sets
// - Per-input flag set by qualifying edge
// - Jack detect has separate rise, fall flags
// - Flags readable anytime or after request
// - Raw status shows input level, shared
// - Masked input neither sets flag nor requests
// - Each request is OR of own flags
// - Flags sticky until written one; request follows
// - GPIO debounce per pin on 32kHz tick
// - Lock inputs always debounced, needs clock
// - Raw status independent of debounce clocks
// - Global mask; status shows request after global mask
// - Request pin active low, polarity invertible
// - Request pin push-pull or open drain
// - Secondary request triggers DSP firmware
// - Either request routable to GPIO
// - After reset only boot done unmasked
// - Rate converter lock flags on both edges
// - Timer final count sets its flag
// - Logger FIFO condition sets its flag
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define DIC_CLK_HZ 100000000
`define DIC_F32K_HZ 32000
`define DIC_DIV32K (`DIC_CLK_HZ / `DIC_F32K_HZ)
`define DIC_DIV_W 12
`define DIC_DB_SAMPLES 4

// ----------------------------------------
// Source widths
// ----------------------------------------
`define DIC_N_JD 2
`define DIC_N_GPIO 8
`define DIC_N_DSP 4
`define DIC_N_FLL 3
`define DIC_N_ASYNC_RATE_CONVERTER 2
`define DIC_N_TMR 4
`define DIC_N_FIFO 4
`define DIC_N_RAW 29
`define DIC_N_FLAG 31

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DIC_BOOT_BIT 0
`define DIC_JDR_LSB 1
`define DIC_JDF_LSB 3
`define DIC_MASK_RST 31'h7FFF_FFFE
`define DIC_BOTH_EDGE 29'h001F_87F8

`endif

// ### dic_pkg.sv
`default_nettype none
`include "dic_consts.svh"

package dic_pkg;

  // Inputs arriving from pins, asynchronous
  typedef struct packed {
    logic [`DIC_N_ASYNC_RATE_CONVERTER-1:0] async_rate_converter;
    logic [`DIC_N_FLL-1:0] frequency_locked_loop;
    logic acc;
    logic [`DIC_N_GPIO-1:0] gpio;
    logic [`DIC_N_JD-1:0] jd;
  } dic_pin_t;

  // Inputs from on-chip logic on clk_sys
  typedef struct packed {
    logic [`DIC_N_FIFO-1:0] fifo;
    logic [`DIC_N_TMR-1:0] tmr;
    logic [`DIC_N_DSP-1:0] dsp;
    logic boot;
  } dic_core_t;

  // Request pin and routing configuration
  typedef struct packed {
    logic polarity;
    logic drive_od;
    logic gpio_sel;
  } dic_pin_cfg_t;

endpackage : dic_pkg

`default_nettype wire

// ### dic_debounce.sv
`default_nettype none
`include "dic_consts.svh"

module dic_debounce
  import dic_pkg::*;
#(
  parameter int unsigned SAMPLES = `DIC_DB_SAMPLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Sample enable and bypass
  input wire logic tick,
  input wire logic bypass,
  // Level in and filtered out
  input wire logic din,
  output logic dout
);

  localparam int CW = $clog2(SAMPLES + 1);

  // ----------------------------------------
  // Stability counter
  // ----------------------------------------
  logic [CW-1:0] cnt; // Ticks the new level has held
  wire differ = din != dout; // Input disagrees with output
  wire last = cnt == CW'(SAMPLES - 1); // Final sample reached

  // Output changes only after SAMPLES agreeing ticks
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
      dout <= 1'b0;
    end else if (bypass) begin
      // Filter off: follow input directly
      cnt <= '0;
      dout <= din;
    end else if (!differ) begin
      // Glitch gone: restart the count
      cnt <= '0;
    end else if (tick) begin
      if (last) begin
        dout <= din;
        cnt <= '0;
      end else begin
        cnt <= cnt + CW'(1);
      end
    end
  end

endmodule : dic_debounce

`default_nettype wire

// ### dic_irq_ctrl.sv
`default_nettype none
`include "dic_consts.svh"

module dic_irq_ctrl
  import dic_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Interrupt sources
  input wire dic_pin_t pin_src,
  input wire dic_core_t core_src,
  // Debounce clocking and enables
  input wire logic clk32_enable,
  input wire logic system_clock_on,
  input wire logic [`DIC_N_GPIO-1:0] gpio_db_enable,
  // Mask writes, shared data
  input wire logic primary_mask_wr,
  input wire logic secondary_mask_wr,
  input wire logic [`DIC_N_FLAG-1:0] mask_wdata,
  // Flag clears, write one to clear
  input wire logic primary_clr_wr,
  input wire logic secondary_clr_wr,
  input wire logic [`DIC_N_FLAG-1:0] clr_wdata,
  // Global masks and pin configuration
  input wire logic primary_global_mask,
  input wire logic secondary_global_mask,
  input wire dic_pin_cfg_t pin_cfg,
  // Flag and mask readback
  output logic [`DIC_N_FLAG-1:0] primary_flag_set,
  output logic [`DIC_N_FLAG-1:0] secondary_flag_set,
  output logic [`DIC_N_FLAG-1:0] primary_mask,
  output logic [`DIC_N_FLAG-1:0] secondary_mask,
  output logic [`DIC_N_RAW-1:0] raw_status,
  // Request status
  output logic primary_request_status,
  output logic secondary_request_status,
  // Request pin, two signals
  output logic request_pin_out,
  output logic request_pin_oe,
  // Routed requests
  output logic gpio_request_out,
  output logic dsp_fw_trigger
);

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  dic_pin_t pin_meta; // First stage, read only by pin_sync
  dic_pin_t pin_sync; // Second stage, safe to use

  // Two flops on every pin input
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_src;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------
  // 32 kHz sample enable
  // ----------------------------------------
  localparam logic [`DIC_DIV_W-1:0] DIV_LAST =
    `DIC_DIV_W'(`DIC_DIV32K - 1);

  logic [`DIC_DIV_W-1:0] div_cnt; // Divider count
  logic tick32; // One-cycle 32 kHz pulse
  wire div_wrap = div_cnt == DIV_LAST; // Divider at end

  // Divider runs only while software enables it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
      tick32 <= 1'b0;
    end else if (!clk32_enable) begin
      // Stopped clock: no ticks
      div_cnt <= '0;
      tick32 <= 1'b0;
    end else begin
      div_cnt <= div_wrap ? '0 : div_cnt + `DIC_DIV_W'(1);
      tick32 <= div_wrap;
    end
  end

  // Lock filter samples on either clock
  wire fll_tick = tick32 | system_clock_on;

  // ----------------------------------------
  // Debounce filters
  // ----------------------------------------
  logic [`DIC_N_GPIO-1:0] gpio_filt; // Filtered GPIO levels
  logic [`DIC_N_FLL-1:0] fll_filt; // Filtered lock levels

  // GPIO filter, bypassed per pin when off
  for (genvar i = 0; i < `DIC_N_GPIO; i++) begin : g_gpio_db
    dic_debounce u_db (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .tick(tick32),
      .bypass(!gpio_db_enable[i]),
      .din(pin_sync.gpio[i]),
      .dout(gpio_filt[i])
    );
  end

  // Lock filter, never bypassed
  for (genvar i = 0; i < `DIC_N_FLL; i++) begin : g_fll_db
    dic_debounce u_db (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .tick(fll_tick),
      .bypass(1'b0),
      .din(pin_sync.frequency_locked_loop[i]),
      .dout(fll_filt[i])
    );
  end

  // ----------------------------------------
  // Source vectors
  // ----------------------------------------
  // Raw levels, before any filter
  wire [`DIC_N_RAW-1:0] raw_level = {
    core_src.fifo, core_src.tmr, pin_sync.async_rate_converter,
    pin_sync.frequency_locked_loop, pin_sync.acc, core_src.dsp,
    pin_sync.gpio, pin_sync.jd, core_src.boot
  };

  // Qualified levels that feed edge detection
  wire [`DIC_N_RAW-1:0] qual_level = {
    core_src.fifo, core_src.tmr, pin_sync.async_rate_converter,
    fll_filt, pin_sync.acc, core_src.dsp,
    gpio_filt, pin_sync.jd, core_src.boot
  };

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  logic [`DIC_N_RAW-1:0] qual_prev; // Level one cycle ago

  // Remember last qualified level
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      qual_prev <= '0;
    end else begin
      qual_prev <= qual_level;
    end
  end

  wire [`DIC_N_RAW-1:0] rise = qual_level & ~qual_prev; // Rising
  wire [`DIC_N_RAW-1:0] fall = ~qual_level & qual_prev; // Falling

  // Rising for boot, DSP, timer, FIFO; both for the rest
  wire [`DIC_N_RAW-1:0] raw_ev =
    rise | (fall & `DIC_BOTH_EDGE);

  // Jack detect splits into rise and fall flags
  wire [`DIC_N_FLAG-1:0] ev = {
    raw_ev[`DIC_N_RAW-1:3],
    fall[2:1],
    rise[2:1],
    raw_ev[`DIC_BOOT_BIT]
  };

  // ----------------------------------------
  // Two flag sets
  // ----------------------------------------
  logic [1:0][`DIC_N_FLAG-1:0] flag_q; // Latched flags
  logic [1:0][`DIC_N_FLAG-1:0] mask_q; // Per-input masks
  logic [1:0][`DIC_N_FLAG-1:0] next_flag; // Flags next cycle
  logic [1:0] next_req; // Request next, after global mask
  wire [1:0] mask_wr = {secondary_mask_wr, primary_mask_wr};
  wire [1:0] clr_wr = {secondary_clr_wr, primary_clr_wr};
  wire [1:0] gmask = {secondary_global_mask, primary_global_mask};

  // Identical logic for each set, fully independent
  for (genvar s = 0; s < 2; s++) begin : g_set
    // Clear mask from a one-written bit
    wire [`DIC_N_FLAG-1:0] clr_bits =
      clr_wr[s] ? clr_wdata : '0;
    // Unmasked edges of this set
    wire [`DIC_N_FLAG-1:0] set_bits =
      ev & ~mask_q[s];

    // Set applied after clear, so an edge wins
    assign next_flag[s] =
      (flag_q[s] & ~clr_bits) | set_bits;

    // Request is OR of this set, global mask gates
    assign next_req[s] =
      !gmask[s] && (|next_flag[s]);

    // Flag and mask storage
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        flag_q[s] <= '0;
        mask_q[s] <= `DIC_MASK_RST;
      end else begin
        flag_q[s] <= next_flag[s];
        if (mask_wr[s]) begin
          mask_q[s] <= mask_wdata;
        end
      end
    end
  end

  // ----------------------------------------
  // Request pin level
  // ----------------------------------------
  // Active low unless polarity set
  wire next_pin_lvl =
    pin_cfg.polarity ? next_req[0] : !next_req[0];

  // Open drain pulls low only, else push-pull
  wire next_pin_out =
    pin_cfg.drive_od ? 1'b0 : next_pin_lvl;
  wire next_pin_oe =
    pin_cfg.drive_od ? !next_pin_lvl : 1'b1;

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Raw readback, request status and routing
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      raw_status <= '0;
      primary_request_status <= 1'b0;
      secondary_request_status <= 1'b0;
      request_pin_out <= 1'b1;
      request_pin_oe <= 1'b1;
      gpio_request_out <= 1'b0;
      dsp_fw_trigger <= 1'b0;
    end else begin
      // Same raw bits seen through either set
      raw_status <= raw_level;
      primary_request_status <= next_req[0];
      secondary_request_status <= next_req[1];
      request_pin_out <= next_pin_out;
      request_pin_oe <= next_pin_oe;
      // Either request onto the GPIO
      gpio_request_out <= pin_cfg.gpio_sel ?
        next_req[1] : next_req[0];
      dsp_fw_trigger <= next_req[1];
    end
  end

  // Readback straight from the storage flops
  assign primary_flag_set = flag_q[0];
  assign secondary_flag_set = flag_q[1];
  assign primary_mask = mask_q[0];
  assign secondary_mask = mask_q[1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Masked, clear boot flag stays clear
  a_mask_blocks_set: assert property (
    mask_q[0][0] && !flag_q[0][0] |=> !flag_q[0][0]
  ) else $error("masked input set its flag");

  // Flag holds without a clear write
  a_flag_stays_set: assert property (
    flag_q[0][0] && !(primary_clr_wr && clr_wdata[0])
      |=> flag_q[0][0]
  ) else $error("flag dropped without clear");

  // Write one without edge clears the flag
  a_w1c_clears_flag: assert property (
    primary_clr_wr && clr_wdata[0] && !ev[0] |=> !flag_q[0][0]
  ) else $error("write one did not clear");

  // Edge in clearing cycle keeps flag set
  a_edge_beats_clr: assert property (
    primary_clr_wr && clr_wdata[0] && ev[0] && !mask_q[0][0]
      |=> flag_q[0][0]
  ) else $error("clear beat a new edge");

  // Jack fall sets its own flag a cycle later
  a_jack_fall_flag: assert property (
    fall[1] && !mask_q[0][`DIC_JDF_LSB]
      |=> flag_q[0][`DIC_JDF_LSB]
  ) else $error("jack fall flag missed");

  // Sets act alone when masks differ
  a_sets_independent: assert property (
    ev[0] && !mask_q[0][0] && mask_q[1][0] && !flag_q[1][0]
      |=> flag_q[0][0] && !flag_q[1][0]
  ) else $error("flag sets not independent");

  // Status equals OR of flags under global mask
  a_req_is_or: assert property (
    primary_request_status ==
      (!$past(primary_global_mask) && (|flag_q[0]))
  ) else $error("request not OR of flags");

  // Push-pull pin follows request and polarity
  a_pin_polarity: assert property (
    !$past(pin_cfg.drive_od) |-> request_pin_oe &&
      (request_pin_out == ($past(pin_cfg.polarity) ?
        primary_request_status : !primary_request_status))
  ) else $error("pin level wrong");

  // Open drain never drives high
  a_pin_open_drain: assert property (
    $past(pin_cfg.drive_od) |-> !request_pin_out
  ) else $error("open drain drove high");

  // GPIO carries the selected request
  a_gpio_route: assert property (
    gpio_request_out == ($past(pin_cfg.gpio_sel) ?
      secondary_request_status : primary_request_status)
  ) else $error("gpio route wrong");

  // Secondary status equals OR of its own flags
  a_req2_is_or: assert property (
    secondary_request_status ==
      (!$past(secondary_global_mask) && (|flag_q[1]))
  ) else $error("secondary request not OR of flags");

  // Firmware trigger follows the secondary status
  a_dsp_follows: assert property (
    dsp_fw_trigger == secondary_request_status
  ) else $error("firmware trigger wrong");

  // Raw readback mirrors the synced levels
  a_raw_mirror: assert property (
    $past(rst_b) |-> raw_status == $past(raw_level)
  ) else $error("raw status wrong");

  // Lock filter holds while no clock samples it
  a_lock_no_tick: assert property (
    !fll_tick |=> $stable(fll_filt)
  ) else $error("lock filter moved without tick");

  // Masked, clear secondary boot flag stays clear
  a_mask2_blocks_set: assert property (
    mask_q[1][0] && !flag_q[1][0] |=> !flag_q[1][0]
  ) else $error("masked input set secondary flag");

endmodule : dic_irq_ctrl

`default_nettype wire

// ### dic_host_model.sv
`default_nettype none

// ----------------------------------------
// Host processor watching the request pin
// ----------------------------------------
module dic_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Pin drive from the controller
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic polarity,
  // Resolved wire and service count
  output logic pin_level,
  output logic [7:0] req_count
);
  timeunit 1ns;
  timeprecision 1ps;

  logic asserted; // Wire shows an active request
  logic asserted_q; // Last sampled request state

  // Board pull-up holds the wire high when released
  assign pin_level = pin_oe ? pin_out : 1'b1;
  assign asserted = (pin_level == polarity);

  // Count each new request, boot done being the first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      asserted_q <= 1'b0;
      req_count <= 8'h00;
    end else begin
      asserted_q <= asserted;
      if (asserted && !asserted_q) begin
        req_count <= req_count + 8'h01;
      end
    end
  end
endmodule : dic_host_model

`default_nettype wire

// ### tb_dic_irq_ctrl.sv
`default_nettype none
`include "dic_consts.svh"

module tb_dic_irq_ctrl
  import dic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [28:0] BOTH = `DIC_BOTH_EDGE; // Raw bits flagged on both edges
  logic clk_sys, rst_b, clk32_enable, system_clock_on;
  dic_pin_t pin_src;
  dic_core_t core_src;
  logic [`DIC_N_GPIO-1:0] gpio_db_enable;
  logic primary_mask_wr, secondary_mask_wr, primary_clr_wr, secondary_clr_wr;
  logic [`DIC_N_FLAG-1:0] mask_wdata, clr_wdata, primary_flag_set, secondary_flag_set;
  logic [`DIC_N_FLAG-1:0] primary_mask, secondary_mask;
  logic primary_global_mask, secondary_global_mask;
  dic_pin_cfg_t pin_cfg;
  logic [`DIC_N_RAW-1:0] raw_status;
  logic primary_request_status, secondary_request_status, request_pin_out, request_pin_oe;
  logic gpio_request_out, dsp_fw_trigger, pin_level;
  logic [7:0] req_count;
  int num_errors, n_compared;
  logic [30:0] exp_p, exp_s, mask_p, mask_s; // Expected flags and masks
  logic [28:0] cur_raw; // Expected raw levels

  dic_irq_ctrl u_dic_irq_ctrl (.clk_sys, .rst_b, .pin_src, .core_src, .clk32_enable,
    .system_clock_on, .gpio_db_enable, .primary_mask_wr, .secondary_mask_wr, .mask_wdata,
    .primary_clr_wr, .secondary_clr_wr, .clr_wdata, .primary_global_mask,
    .secondary_global_mask, .pin_cfg, .primary_flag_set, .secondary_flag_set, .primary_mask,
    .secondary_mask, .raw_status, .primary_request_status, .secondary_request_status,
    .request_pin_out, .request_pin_oe, .gpio_request_out, .dsp_fw_trigger);

  dic_host_model u_dic_host_model (.clk_sys, .rst_b, .pin_out(request_pin_out),
    .pin_oe(request_pin_oe), .polarity(pin_cfg.polarity), .pin_level, .req_count);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [28:0] raw_of(input dic_pin_t p, input dic_core_t c);
    return {c.fifo, c.tmr, p.async_rate_converter, p.frequency_locked_loop, p.acc, c.dsp, p.gpio, p.jd, c.boot};
  endfunction : raw_of

  // Flags raised by a level change, jack rise and fall kept apart
  function automatic logic [30:0] events(input logic [28:0] o, input logic [28:0] n);
    logic [28:0] e;
    e = (BOTH & (o ^ n)) | (~BOTH & n & ~o);
    return {e[28:3], o[2:1] & ~n[2:1], e[2:0]};
  endfunction : events

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  // One-cycle write: 0/1 mask, 2/3 clear, primary then secondary
  task automatic wr(input int kind, input logic [30:0] d);
    @(negedge clk_sys);
    mask_wdata = d;
    clr_wdata = d;
    primary_mask_wr = (kind == 0);
    secondary_mask_wr = (kind == 1);
    primary_clr_wr = (kind == 2);
    secondary_clr_wr = (kind == 3);
    @(negedge clk_sys);
    {primary_mask_wr, secondary_mask_wr, primary_clr_wr, secondary_clr_wr} = 4'h0;
    case (kind)
      0: mask_p = d;
      1: mask_s = d;
      2: exp_p &= ~d;
      default: exp_s &= ~d;
    endcase
  endtask : wr

  task automatic check_all();
    logic ps;
    logic ss;
    ps = !primary_global_mask && (exp_p != 31'h0);
    ss = !secondary_global_mask && (exp_s != 31'h0);
    chk("primary flags", primary_flag_set, exp_p);
    chk("secondary flags", secondary_flag_set, exp_s);
    chk("primary mask", primary_mask, mask_p);
    chk("secondary mask", secondary_mask, mask_s);
    chk("raw status", raw_status, cur_raw);
    chk("primary status", primary_request_status, ps);
    chk("secondary status", secondary_request_status, ss);
    chk("pin level", pin_level, pin_cfg.polarity ? ps : !ps);
    chk("gpio request", gpio_request_out, pin_cfg.gpio_sel ? ss : ps);
    chk("dsp trigger", dsp_fw_trigger, ss);
  endtask : check_all

  // Drive new source levels, track expected flags, then check
  task automatic apply(input dic_pin_t p, input dic_core_t c);
    logic [30:0] ev;
    ev = events(cur_raw, raw_of(p, c));
    @(negedge clk_sys);
    pin_src = p;
    core_src = c;
    cur_raw = raw_of(p, c);
    exp_p |= ev & ~mask_p;
    exp_s |= ev & ~mask_s;
    repeat (16) @(negedge clk_sys);
    check_all();
  endtask : apply

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    dic_pin_t p;
    dic_core_t c;
    int k;
    void'($urandom(56086));
    {rst_b, clk32_enable, system_clock_on, gpio_db_enable} = '0;
    {pin_src, core_src, pin_cfg, primary_global_mask, secondary_global_mask} = '0;
    {primary_mask_wr, secondary_mask_wr, primary_clr_wr, secondary_clr_wr} = 4'h0;
    {mask_wdata, clr_wdata, exp_p, exp_s, cur_raw} = '0;
    num_errors = 0;
    n_compared = 0;
    mask_p = `DIC_MASK_RST;
    mask_s = `DIC_MASK_RST;
    system_clock_on = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    check_all();
    chk("pin enable", request_pin_oe, 1'b1);
    $display("test reset done");
    // Boot done is the only unmasked source
    c = core_src;
    c.boot = 1'b1;
    apply(pin_src, c);
    chk("host requests", req_count, 8'h01);
    wr(2, 31'h1);
    wr(3, 31'h1);
    check_all();
    $display("test boot done");
    // Lock inputs give no flag with every clock off, raw still live
    wr(0, 31'h0);
    wr(1, 31'h0);
    system_clock_on = 1'b0;
    p = pin_src;
    p.frequency_locked_loop = 3'h7;
    pin_src = p;
    cur_raw = raw_of(pin_src, core_src);
    repeat (16) @(negedge clk_sys);
    check_all();
    system_clock_on = 1'b1;
    exp_p |= 31'h0007_0000 << 2;
    exp_s |= 31'h0007_0000 << 2;
    repeat (16) @(negedge clk_sys);
    check_all();
    $display("test lock debounce done");
    // Random sources, masks, clears and pin settings
    for (k = 0; k < 80; k++) begin
      p = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($urandom);
      c = (k == 0) ? 13'h1FFF : (k == 1) ? 13'h0000 : 13'($urandom);
      if (k % 8 == 7) begin
        wr(0, 31'($urandom) & 31'($urandom));
        wr(1, 31'($urandom) & 31'($urandom));
      end
      {primary_global_mask, secondary_global_mask} = 2'($urandom);
      pin_cfg = 3'($urandom);
      apply(p, c);
      if (k % 3 == 0) begin
        wr(2 + k % 2, 31'($urandom));
      end
    end
    $display("test random done");
    // Zero write keeps a flag; an edge beats a clear in the same cycle
    wr(0, 31'h0);
    wr(2, 31'h7FFF_FFFF);
    c = core_src;
    c.dsp[0] = 1'b0;
    apply(pin_src, c);
    c.dsp[0] = 1'b1;
    apply(pin_src, c);
    c.dsp[0] = 1'b0;
    apply(pin_src, c);
    wr(2, 31'h0);
    check_all();
    c.dsp[0] = 1'b1;
    exp_s |= events(cur_raw, raw_of(pin_src, c)) & ~mask_s;
    @(negedge clk_sys);
    core_src = c;
    clr_wdata = 31'h7FFF_FFFF;
    primary_clr_wr = 1'b1;
    @(negedge clk_sys);
    primary_clr_wr = 1'b0;
    cur_raw = raw_of(pin_src, c);
    exp_p = 31'h0000_2000;
    repeat (16) @(negedge clk_sys);
    check_all();
    $display("test clear race done");
    // GPIO debounce on the 32 kHz tick
    gpio_db_enable = 8'h01;
    clk32_enable = 1'b1;
    repeat (20000) @(negedge clk_sys);
    wr(2, 31'h7FFF_FFFF);
    wr(3, 31'h7FFF_FFFF);
    p = pin_src;
    p.gpio[0] = ~p.gpio[0];
    exp_s |= events(cur_raw, raw_of(p, core_src)) & ~mask_s;
    @(negedge clk_sys);
    pin_src = p;
    cur_raw = raw_of(p, core_src);
    repeat (16) @(negedge clk_sys);
    chk("filtered flag", primary_flag_set[5], 1'b0);
    for (k = 0; k < 20000 && primary_flag_set[5] !== 1'b1; k++) begin
      @(negedge clk_sys);
    end
    exp_p[5] = 1'b1;
    @(negedge clk_sys);
    check_all();
    $display("test gpio debounce done");
    summarize();
  end
endmodule : tb_dic_irq_ctrl

`default_nettype wire
